// ### src/dfh_diag.v
// Purpose: Gateway and node diagnostic status registers with test commands
// Assumes: Conditions are synchronous live levels; events are one-cycle pulses
// Notes:   Command word arrives as a value with a write strobe; counters have no reset
`timescale 1ns/1ps
`include "dfh_defs.vh"
module dfh_diag #(
  parameter NODES = 6,
  parameter CW    = 16
) (
  input  wire             clk_sys,
  input  wire             reset_n,
  input  wire [7:0]       gw_rd_addr,
  output reg  [15:0]      gw_rd_data,
  input  wire [7:0]       node_rd_addr,
  output reg  [15:0]      node_rd_data,
  input  wire             node_cmd_wr,
  input  wire [15:0]      node_cmd_data,
  output wire [15:0]      node_global_command,
  input  wire [7:0]       alarm_control,
  input  wire             gw_sys_alarm,
  input  wire [NODES-1:0] gw_new_data,
  input  wire             gw_new_data_ack,
  input  wire             gw_cmd_done,
  input  wire             gw_stat_clear,
  input  wire             spi_frame_end,
  input  wire [3:0]       spi_edge_count,
  input  wire             gw_flash_upd_fail,
  input  wire             gw_flash_test_start,
  input  wire             gw_flash_write_done,
  input  wire             supply_high,
  input  wire             supply_low,
  input  wire             node_sys_error,
  input  wire [3:0]       node_alarm,
  input  wire             node_rec_intr,
  input  wire             node_flash_upd_fail,
  input  wire             node_flash_write_done,
  output wire             self_test_start,
  input  wire             self_test_done,
  input  wire             self_test_fail,
  output wire             node_cksum_start,
  input  wire             node_cksum_done,
  input  wire             node_cksum_fail,
  output wire             gw_cksum_start,
  input  wire             gw_cksum_done,
  input  wire             gw_cksum_fail
);
  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  reg [1:0] rst_sync;
  wire      rst_n;
  // Only the second stage feeds the design
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rst_sync <= 2'b00;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  // ----------------------------------------------------------------
  // Flag update: set wins over clear
  // ----------------------------------------------------------------
  function [15:0] flag_next;
    input [15:0] cur;
    input [15:0] set;
    input [15:0] clr;
    begin
      flag_next = (cur & ~clr) | set;
    end
  endfunction

  // ----------------------------------------------------------------
  // Commands and test sequencers
  // ----------------------------------------------------------------
  wire st_busy, st_done, st_fail;
  wire nf_busy, nf_done, nf_fail;
  wire gf_done, gf_fail;
  wire cmd_st     = node_cmd_wr & node_cmd_data[`DFH_CMD_SELF_TEST];
  wire cmd_ft     = node_cmd_wr & node_cmd_data[`DFH_CMD_FLASH_TEST];
  wire cmd_clear  = node_cmd_wr & node_cmd_data[`DFH_CMD_CLEAR_STAT];
  reg  clear_busy;

  dfh_test_seq u_self_test (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n),
    .start     (cmd_st),
    .eng_done  (self_test_done),
    .eng_fail  (self_test_fail),
    .eng_start (self_test_start),
    .busy      (st_busy),
    .done      (st_done),
    .fail      (st_fail)
  );

  dfh_test_seq u_node_cksum (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n),
    .start     (cmd_ft),
    .eng_done  (node_cksum_done),
    .eng_fail  (node_cksum_fail),
    .eng_start (node_cksum_start),
    .busy      (nf_busy),
    .done      (nf_done),
    .fail      (nf_fail)
  );

  dfh_test_seq u_gw_cksum (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n),
    .start     (gw_flash_test_start),
    .eng_done  (gw_cksum_done),
    .eng_fail  (gw_cksum_fail),
    .eng_start (gw_cksum_start),
    .busy      (),
    .done      (gf_done),
    .fail      (gf_fail)
  );

  // Clear-status is finished one cycle after it is taken
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      clear_busy <= 1'b0;
    end else begin
      clear_busy <= cmd_clear;
    end
  end

  // ----------------------------------------------------------------
  // Command readback, each bit drops when its function ends
  // ----------------------------------------------------------------
  reg  [15:0] cmd_view;

  always @* begin
    cmd_view                      = 16'h0000;
    cmd_view[`DFH_CMD_SELF_TEST]  = st_busy;
    cmd_view[`DFH_CMD_CLEAR_STAT] = clear_busy;
    cmd_view[`DFH_CMD_FLASH_TEST] = nf_busy;
  end

  assign node_global_command = cmd_view;

  // ----------------------------------------------------------------
  // Node status register
  // ----------------------------------------------------------------
  reg  [15:0] node_latched;
  reg  [15:0] next_node_latched;
  reg  [15:0] node_live;
  reg  [15:0] node_set;
  reg  [15:0] node_clr;
  reg  [15:0] node_stat;
  wire        alm_latch = alarm_control[`DFH_ALM_LATCH_BIT];

  always @* begin
    node_live = 16'h0000;
    node_live[`DFH_B_LOW_SUPPLY]  = supply_low;
    node_live[`DFH_B_HIGH_SUPPLY] = supply_high;
    node_live[`DFH_B_FLASH_UPD]   = node_flash_upd_fail;
    node_live[`DFH_B_REC_INTR]    = node_rec_intr;
    node_live[`DFH_B_SYS_ALARM]   = node_sys_error;
    node_live[`DFH_B_ALM1_X]      = node_alarm[0];
    node_live[`DFH_B_ALM1_Y]      = node_alarm[1];
    node_live[`DFH_B_ALM2_X]      = node_alarm[2];
    node_live[`DFH_B_ALM2_Y]      = node_alarm[3];
    node_set = node_live;
    node_set[`DFH_B_SELF_TEST]  = st_done & st_fail;
    node_set[`DFH_B_FLASH_TEST] = nf_done & nf_fail;
    node_clr = 16'h0000;
    // Low flags drop when the condition goes or on clear-status
    node_clr = (~node_live | {16{cmd_clear}}) & `DFH_NODE_LOW_MASK;
    // Test results are replaced when a test passes
    node_clr[`DFH_B_SELF_TEST]  = cmd_clear | (st_done & ~st_fail);
    node_clr[`DFH_B_FLASH_TEST] = cmd_clear | (nf_done & ~nf_fail);
    // Alarm byte latches only under alarm control
    if (alm_latch) begin
      node_clr = node_clr | ({16{cmd_clear}} & `DFH_NODE_ALARM_MASK);
    end else begin
      node_clr = node_clr | `DFH_NODE_ALARM_MASK;
    end
    next_node_latched = flag_next(node_latched, node_set, node_clr);
  end

  // ----------------------------------------------------------------
  // Node flag storage
  // ----------------------------------------------------------------
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      node_latched <= `DFH_STAT_RESET;
    end else begin
      node_latched <= next_node_latched;
    end
  end

  // ----------------------------------------------------------------
  // Node read view
  // ----------------------------------------------------------------
  // Alarm byte shows the live condition unless latching is on
  always @* begin
    node_stat = node_latched;
    if (!alm_latch) begin
      node_stat = (node_latched & ~`DFH_NODE_ALARM_MASK) |
                  (node_live & `DFH_NODE_ALARM_MASK);
    end
  end

  // ----------------------------------------------------------------
  // Gateway status register
  // ----------------------------------------------------------------
  reg  [15:0] gw_stat;
  reg  [15:0] next_gw_stat;
  reg  [15:0] gw_set;
  reg  [15:0] gw_clr;
  wire        spi_bad = spi_frame_end & (spi_edge_count != `DFH_SPI_FRAME_BITS);

  always @* begin
    gw_set = 16'h0000;
    gw_set[`DFH_B_LOW_SUPPLY]  = supply_low;
    gw_set[`DFH_B_HIGH_SUPPLY] = supply_high;
    gw_set[`DFH_B_FLASH_UPD]   = gw_flash_upd_fail;
    gw_set[`DFH_B_SPI_FRAME]   = spi_bad;
    gw_set[`DFH_B_FLASH_TEST]  = gf_done & gf_fail;
    gw_set[`DFH_B_CMD_DONE]    = gw_cmd_done | gf_done;
    gw_set[`DFH_B_SYS_ALARM]   = gw_sys_alarm;
    gw_set[`DFH_B_NEW_DATA_LO +: NODES] = gw_new_data;
    // Gateway flags stay set until the host clears them or, for the flash-test flag, a gateway test passes
    gw_clr = {16{gw_stat_clear}};
    // New-data bits also drop on acknowledge
    gw_clr[`DFH_B_NEW_DATA_LO +: NODES] = {NODES{gw_stat_clear | gw_new_data_ack}};
    gw_clr[`DFH_B_FLASH_TEST] = gw_stat_clear | (gf_done & ~gf_fail);
    next_gw_stat = flag_next(gw_stat, gw_set, gw_clr) & `DFH_GW_USED_MASK;
  end

  // ----------------------------------------------------------------
  // Gateway flag storage
  // ----------------------------------------------------------------
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      gw_stat <= `DFH_STAT_RESET;
    end else begin
      gw_stat <= next_gw_stat;
    end
  end

  // ----------------------------------------------------------------
  // Flash write counters
  // ----------------------------------------------------------------
  wire [CW-1:0] gw_fcount;
  wire [CW-1:0] node_fcount;

  dfh_flash_count #(.WIDTH(CW)) u_gw_fcount (
    .clk_sys    (clk_sys),
    .write_done (gw_flash_write_done),
    .count      (gw_fcount)
  );

  dfh_flash_count #(.WIDTH(CW)) u_node_fcount (
    .clk_sys    (clk_sys),
    .write_done (node_flash_write_done),
    .count      (node_fcount)
  );

  // ----------------------------------------------------------------
  // Read ports, registered
  // ----------------------------------------------------------------
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      gw_rd_data   <= 16'h0000;
      node_rd_data <= 16'h0000;
    end else begin
      // Unmapped addresses read as zero
      case (gw_rd_addr)
        `DFH_OFS_FLASH_CNT: gw_rd_data <= gw_fcount[15:0];
        `DFH_OFS_GW_STAT:   gw_rd_data <= gw_stat;
        default:            gw_rd_data <= 16'h0000;
      endcase
      case (node_rd_addr)
        `DFH_OFS_FLASH_CNT: node_rd_data <= node_fcount[15:0];
        `DFH_OFS_NODE_STAT: node_rd_data <= node_stat;
        default:            node_rd_data <= 16'h0000;
      endcase
    end
  end

endmodule

// ### inc/dfh_defs.vh
// Purpose: Offsets, bit positions and reset values of the diagnostic flag block
// Assumes: 16-bit registers, byte offsets as printed
// Notes:   Definitions only
`ifndef DFH_DEFS_VH
`define DFH_DEFS_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define DFH_OFS_FLASH_CNT     8'h04
`define DFH_OFS_GW_STAT       8'h2c
`define DFH_OFS_NODE_STAT     8'h34
`define DFH_OFS_NODE_CMD      8'h36
`define DFH_STAT_RESET        16'h0000

// ----------------------------------------------------------------
// Status bit positions
// ----------------------------------------------------------------
`define DFH_B_LOW_SUPPLY      0
`define DFH_B_HIGH_SUPPLY     1
`define DFH_B_FLASH_UPD       2
`define DFH_B_SPI_FRAME       3
`define DFH_B_REC_INTR        4
`define DFH_B_SELF_TEST       5
`define DFH_B_FLASH_TEST      6
`define DFH_B_CMD_DONE        7
`define DFH_B_NEW_DATA_LO     8
`define DFH_B_SYS_ALARM       14
`define DFH_B_ALM1_X          8
`define DFH_B_ALM1_Y          9
`define DFH_B_ALM2_X          11
`define DFH_B_ALM2_Y          12
`define DFH_NODE_LOW_MASK     16'h0077
`define DFH_NODE_ALARM_MASK   16'h5b00
`define DFH_GW_USED_MASK      16'h7fcf

// ----------------------------------------------------------------
// Command bits and alarm control
// ----------------------------------------------------------------
`define DFH_CMD_SELF_TEST     2
`define DFH_CMD_CLEAR_STAT    4
`define DFH_CMD_FLASH_TEST    5
`define DFH_ALM_LATCH_BIT     7
`define DFH_SPI_FRAME_BITS    4'hf

`endif

// ### src/dfh_test_seq.v
// Purpose: Runs one diagnostic test, holds busy until the engine reports done
// Assumes: Engine done is a one-cycle pulse with its result
// Notes:   Busy doubles as the self-clearing command bit
`timescale 1ns/1ps
module dfh_test_seq (
  input  wire clk_sys,
  input  wire rst_n,
  input  wire start,
  input  wire eng_done,
  input  wire eng_fail,
  output wire eng_start,
  output reg  busy,
  output reg  done,
  output reg  fail
);
  localparam ST_IDLE = 2'b01;
  localparam ST_RUN  = 2'b10;
  reg [1:0] state;

  assign eng_start = (state == ST_IDLE) & start;

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      busy  <= 1'b0;
      done  <= 1'b0;
      fail  <= 1'b0;
    end else begin
      done <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (start) begin
            state <= ST_RUN;
            busy  <= 1'b1;
          end
        end
        ST_RUN: begin
          if (eng_done) begin
            state <= ST_IDLE;
            busy  <= 1'b0;
            done  <= 1'b1;
            fail  <= eng_fail;
          end
        end
        default: begin
          state <= ST_IDLE;
          busy  <= 1'b0;
        end
      endcase
    end
  end
endmodule

// ### src/dfh_flash_count.v
// Purpose: Flash write cycle counter
// Assumes: Write-done is a one-cycle pulse
// Notes:   No reset, value survives reset
`timescale 1ns/1ps
module dfh_flash_count #(
  parameter WIDTH = 16
) (
  input  wire             clk_sys,
  input  wire             write_done,
  output reg  [WIDTH-1:0] count
);
  initial count = {WIDTH{1'b0}};

  always @(posedge clk_sys) begin
    if (write_done) begin
      count <= count + {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end
endmodule

// ### verif/dfh_engine_model.sv
// Purpose: Test engine stand-in, answers a start pulse with done and result
// Assumes: Start is a one-cycle pulse, dly of one or more
// Notes:   Result line shows the inverse between answers
`timescale 1ns/1ps
module dfh_engine_model (
  input  wire       clk_sys,
  input  wire       start,
  input  wire [3:0] dly,
  input  wire       fail_set,
  output reg        done,
  output reg        fail
);
  reg [3:0] cnt = 4'h0;
  initial done = 1'b0;
  initial fail = 1'b0;
  always @(posedge clk_sys) begin
    done <= 1'b0;
    fail <= ~fail_set;
    if (start)
      cnt <= dly;
    else if (cnt != 4'h0)
      cnt <= cnt - 4'h1;
    if (cnt == 4'h1 && !start) begin
      done <= 1'b1;
      fail <= fail_set;
    end
  end
endmodule

// ### verif/dfh_diag_checker.sv
// Purpose: Port assertions for the diagnostic flag block
// Assumes: Read data one cycle after address
// Notes:   Checks wait until the internal reset copy has settled
`timescale 1ns/1ps
module dfh_diag_checker (
  input wire        clk_sys,
  input wire        reset_n,
  input wire [7:0]  gw_rd_addr,
  input wire [15:0] gw_rd_data,
  input wire [7:0]  node_rd_addr,
  input wire [15:0] node_rd_data,
  input wire        node_cmd_wr,
  input wire [15:0] node_cmd_data,
  input wire [15:0] node_global_command,
  input wire        supply_high,
  input wire        node_flash_write_done,
  input wire        self_test_start,
  input wire        self_test_done,
  input wire        self_test_fail,
  input wire        node_cksum_start
);
  logic [1:0] up;
  always_ff @(posedge clk_sys or negedge reset_n)
    if (!reset_n)
      up <= 2'd0;
    else if (up != 2'd3)
      up <= up + 2'd1;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n || up != 2'd3);
  sequence st_seen;
    self_test_done && node_rd_addr == 8'h34 ##1 node_rd_addr == 8'h34
    ##1 node_rd_addr == 8'h34;
  endsequence
  sequence hi_seen;
    supply_high && node_rd_addr == 8'h34 ##1 node_rd_addr == 8'h34;
  endsequence
  sequence wr_seen;
    node_flash_write_done && node_rd_addr == 8'h04
    ##1 !node_flash_write_done && node_rd_addr == 8'h04;
  endsequence
  a_gw_unused: assert property (gw_rd_addr == 8'h2c |=>
    (gw_rd_data & 16'h8030) == 16'h0000) else $error("gateway unused bits set");
  a_node_unused: assert property (node_rd_addr == 8'h34 |=>
    (node_rd_data & 16'ha488) == 16'h0000) else $error("node unused bits set");
  a_selftest_start: assert property (node_cmd_wr && node_cmd_data[2]
    && !node_global_command[2] |-> self_test_start) else $error("self-test not started");
  a_selftest_refuse: assert property (node_global_command[2]
    |-> !self_test_start) else $error("self-test restarted while running");
  a_cmd_selfclear: assert property (self_test_done
    |=> !node_global_command[2]) else $error("command bit not cleared");
  a_cmd_hold: assert property (self_test_start && !self_test_done
    |=> node_global_command[2]) else $error("command bit not shown");
  a_selftest_post: assert property (st_seen
    |=> node_rd_data[5] == $past(self_test_fail, 3)) else $error("self-test result wrong");
  a_supply_flag: assert property (hi_seen
    |=> node_rd_data[1]) else $error("high supply flag missing");
  a_count_step: assert property (wr_seen
    |=> node_rd_data == $past(node_rd_data) + 16'h0001) else $error("count step wrong");
  a_cksum_start: assert property (node_cmd_wr && node_cmd_data[5]
    && !node_global_command[5] |-> node_cksum_start) else $error("checksum not started");
endmodule
bind dfh_diag dfh_diag_checker i_dfh_diag_checker (.*);

// ### verif/dfh_diag_tb.sv
// Purpose: Directed bench for the diagnostic flag block
// Assumes: Read data one cycle after address, requests from third edge
// Notes:   Flash counters start at zero and survive reset
`timescale 1ns/1ps
module dfh_diag_tb;
  logic        clk_sys = 1'b0;
  logic        reset_n = 1'b0;
  logic [7:0]  gw_rd_addr = 8'h00, node_rd_addr = 8'h00, alarm_control = 8'h00;
  logic [15:0] node_cmd_data = 16'h0000, rg, rn;
  logic [5:0]  gw_new_data = 6'h00;
  logic [3:0]  node_alarm = 4'h0, spi_edge_count = 4'hf, dly = 4'h1;
  logic node_cmd_wr = 0, gw_sys_alarm = 0, gw_new_data_ack = 0, gw_cmd_done = 0;
  logic gw_stat_clear = 0, spi_frame_end = 0, gw_flash_upd_fail = 0, supply_high = 0;
  logic gw_flash_test_start = 0, gw_flash_write_done = 0, supply_low = 0, eng_fail = 0;
  logic node_sys_error = 0, node_rec_intr = 0, node_flash_upd_fail = 0;
  logic node_flash_write_done = 0;
  wire [15:0] gw_rd_data, node_rd_data, node_global_command;
  wire self_test_start, self_test_done, self_test_fail, node_cksum_start;
  wire node_cksum_done, node_cksum_fail, gw_cksum_start, gw_cksum_done, gw_cksum_fail;
  int n_fail = 0;
  int checks_done = 0;
  dfh_diag i_dfh_diag (.*);
  dfh_engine_model i_dfh_engine_model_st (.clk_sys(clk_sys), .start(self_test_start),
    .dly(dly), .fail_set(eng_fail), .done(self_test_done), .fail(self_test_fail));
  dfh_engine_model i_dfh_engine_model_nc (.clk_sys(clk_sys), .start(node_cksum_start),
    .dly(dly), .fail_set(eng_fail), .done(node_cksum_done), .fail(node_cksum_fail));
  dfh_engine_model i_dfh_engine_model_gc (.clk_sys(clk_sys), .start(gw_cksum_start),
    .dly(dly), .fail_set(eng_fail), .done(gw_cksum_done), .fail(gw_cksum_fail));
  initial begin
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic stop_test;
    if (n_fail == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic cmp(input string nm, input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rd(input logic [7:0] ag, input logic [7:0] an);
    gw_rd_addr = ag;
    node_rd_addr = an;
    tick(2);
    rg = gw_rd_data;
    rn = node_rd_data;
  endtask
  task automatic cmd(input logic [15:0] d);
    node_cmd_data = d;
    node_cmd_wr = 1'b1;
    tick(1);
    node_cmd_wr = 1'b0;
  endtask
  task automatic gclr;
    gw_stat_clear = 1'b1;
    tick(1);
    gw_stat_clear = 1'b0;
  endtask
  task automatic idle(input int b);
    int i;
    for (i = 0; i < 40 && node_global_command[b] !== 1'b0; i++)
      tick(1);
    if (node_global_command[b] !== 1'b0) begin
      n_fail++;
      $display("[ERR] command bit %0d expected 0 seen %b", b, node_global_command[b]);
      stop_test;
    end
  endtask
  task automatic t_count;
    gw_rd_addr = 8'h04;
    node_rd_addr = 8'h04;
    node_flash_write_done = 1'b1;
    gw_flash_write_done = 1'b1;
    gw_sys_alarm = 1'b1;
    tick(3);
    node_flash_write_done = 1'b0;
    gw_flash_write_done = 1'b0;
    gw_sys_alarm = 1'b0;
    rd(8'h04, 8'h04);
    cmp("gw count", 16'h0003, rg);
    cmp("node count", 16'h0003, rn);
    reset_n = 1'b0;
    tick(2);
    reset_n = 1'b1;
    tick(3);
    rd(8'h04, 8'h34);
    cmp("count kept", 16'h0003, rg);
    cmp("node status reset", 16'h0000, rn);
    rd(8'h2c, 8'h04);
    cmp("gw status reset", 16'h0000, rg);
    cmp("node count kept", 16'h0003, rn);
  endtask
  task automatic t_supply;
    rd(8'h10, 8'h12);
    cmp("gw unmapped", 16'h0000, rg);
    cmp("node unmapped", 16'h0000, rn);
    supply_high = 1'b1;
    supply_low = 1'b1;
    rd(8'h2c, 8'h34);
    cmp("gw supply", 16'h0003, rg);
    cmp("node supply", 16'h0003, rn);
    supply_low = 1'b0;
    gclr;
    rd(8'h2c, 8'h34);
    cmp("gw clear held", 16'h0002, rg);
    cmp("node follows", 16'h0002, rn);
    supply_high = 1'b0;
    gclr;
    rd(8'h2c, 8'h34);
    cmp("gw cleared", 16'h0000, rg);
  endtask
  task automatic t_node;
    node_flash_upd_fail = 1'b1;
    node_rec_intr = 1'b1;
    node_sys_error = 1'b1;
    node_alarm = 4'hf;
    rd(8'h2c, 8'h34);
    cmp("node flags", 16'h5b14, rn);
    cmd(16'h0010);
    rd(8'h2c, 8'h34);
    cmp("node persist", 16'h5b14, rn);
    node_flash_upd_fail = 1'b0;
    node_rec_intr = 1'b0;
    node_sys_error = 1'b0;
    node_alarm = 4'h0;
    rd(8'h2c, 8'h34);
    cmp("node gone", 16'h0000, rn);
    alarm_control = 8'h80;
    node_alarm = 4'hf;
    tick(1);
    node_alarm = 4'h0;
    rd(8'h2c, 8'h34);
    cmp("alarm latched", 16'h1b00, rn);
    cmd(16'h0010);
    rd(8'h2c, 8'h34);
    cmp("alarm cleared", 16'h0000, rn);
    alarm_control = 8'h00;
  endtask
  task automatic t_test;
    eng_fail = 1'b1;
    cmd(16'h0004);
    cmp("command bit", 16'h0004, node_global_command & 16'h0004);
    idle(2);
    rd(8'h2c, 8'h34);
    cmp("self-test fail", 16'h0020, rn);
    eng_fail = 1'b0;
    dly = 4'h9;
    cmd(16'h0004);
    tick(1);
    cmd(16'h0004);
    idle(2);
    rd(8'h2c, 8'h34);
    cmp("self-test pass", 16'h0000, rn);
    eng_fail = 1'b1;
    cmd(16'h0020);
    gw_flash_test_start = 1'b1;
    gw_cmd_done = 1'b1;
    tick(1);
    gw_flash_test_start = 1'b0;
    gw_cmd_done = 1'b0;
    idle(5);
    tick(2);
    rd(8'h2c, 8'h34);
    cmp("gw flash test", 16'h00c0, rg);
    cmp("node flash test", 16'h0040, rn);
  endtask
  task automatic t_gw;
    gclr;
    gw_new_data = 6'h21;
    gw_sys_alarm = 1'b1;
    gw_flash_upd_fail = 1'b1;
    spi_frame_end = 1'b1;
    tick(1);
    gw_new_data = 6'h00;
    gw_sys_alarm = 1'b0;
    gw_flash_upd_fail = 1'b0;
    spi_edge_count = 4'h7;
    gw_new_data_ack = 1'b1;
    tick(1);
    gw_new_data_ack = 1'b0;
    rg = gw_rd_data;
    cmp("gw events", 16'h6104, rg);
    spi_frame_end = 1'b0;
    rd(8'h2c, 8'h34);
    cmp("gw ack and frame", 16'h400c, rg);
  endtask
  initial begin
    tick(2);
    reset_n = 1'b1;
    tick(3);
    t_count;
    t_supply;
    t_node;
    t_test;
    rd(8'h2c, 8'h34);
    t_gw;
    stop_test;
  end
endmodule
